// ### hw/regulator_fault_supervisor.sv
// supervisor of the main and auxiliary regulators with APB status and control
//
// The placing of the registers and register access over APB were decided locally.

// How it works
// - At the thermal warning level the main regulator stays on.
// - At the thermal shutdown level in active operation the main regulator and all wake sources are turned off.
// - After the restart delay the main regulator is turned back on without host action.
// - Seven failed restarts within one minute force battery standby and set forced sleep.
// - The aux mode bit selects low-drop operation at 0, its reset value, and tracking at 1.
// - A regulator output below its failure level past the filter time latches its fail flag.
// - After turn-on, an output still low past the short filter is a short and turns it off.
// - A main short forces battery standby and sets forced sleep and main fail.
// - An aux short sets the aux short flag and the aux fail flag.
// - Once an output rises above its failure level, short checking stops till next turn-on.
// - A lasting short after checking ends turns main off at shutdown and aux off at warning.
// - A lost regulator supply pin turns off all battery-supplied power outputs.
// - Signal ground loss is reported only after the comparator holds for 7 us.
// - Battery standby turns off regulators per config, power outputs and bus transmitters.
// - Every wake from battery standby gives a reset pulse to the host.
module regulator_fault_supervisor #(
   parameter int RESTART_CYCLES = fault_sup_pkg::RESTART_CYC,
   parameter int SHORT_CYCLES   = fault_sup_pkg::SHORT_CYC,
   parameter int WINDOW_CYCLES  = fault_sup_pkg::WINDOW_CYC
) (
   input  wire logic        pclk,                   // 20 MHz clock
   input  wire logic        presetn,                // async reset, active low
   input  wire logic        psel,                   // apb select
   input  wire logic        penable,                // apb enable
   input  wire logic        pwrite,                 // apb direction
   input  wire logic [7:0]  paddr,                  // apb byte address
   input  wire logic [31:0] pwdata,                 // apb write data
   output logic      [31:0] prdata,                 // apb read data
   output logic             pready,                 // apb ready
   output logic             pslverr,                // apb error
   input  wire logic        thermal_warning_level,  // die above warning level
   input  wire logic        thermal_shutdown_level, // die above shutdown level
   input  wire logic        main_below_fail,        // main output under fail level
   input  wire logic        aux_below_fail,         // aux output under fail level
   input  wire logic        supply_pin_lost,        // regulator supply pin open
   input  wire logic        signal_ground_cmp,      // signal ground loss comparator
   input  wire logic        wake_event,             // any wake source
   output logic             main_regulator_en,      // main regulator on
   output logic             aux_regulator_en,       // aux regulator on
   output logic             aux_reg_mode_select,    // 1 tracks the main output
   output logic             reset_threshold_sel_hi, // reset threshold select
   output logic             reset_threshold_sel_lo, // reset threshold select
   output logic             power_out_en,           // battery-supplied outputs on
   output logic             contact_supply_switch,  // contact supply switch on
   output logic             bus_tx_en,              // bus transmitters on
   output logic             wake_sources_en,        // wake sources armed
   output logic             host_reset_output_n     // reset to host, active low
);
   import fault_sup_pkg::*;

   typedef struct packed {
      sup_state_t        state;
      logic [31:0]       tmr;
      logic [31:0]       prdata;
      logic              pready;
      logic              pslverr;
      logic [CTRL_W-1:0] ctrl;
      logic [FLAG_W-1:0] flags;
      logic              warn1, warn2, sd1, sd2, lost1, lost2, wake1, wake2;
      logic              main_en, aux_en, main_armed, aux_armed;
      logic              pwr_en, tx_en, wake_en, rst_n;
   } sup_t;

   // power-on starts in the wake state so the host sees a reset pulse
   localparam sup_t SUP_RST = '{state: ST_WAKE, tmr: 32'(PULSE_CYC), ctrl: CTRL_RST,
      main_en: 1'b1, aux_en: 1'b1, main_armed: 1'b1, aux_armed: 1'b1, default: '0};

   sup_t s;
   sup_t n;

   logic main_lvl, main_fail_q, main_short_q;
   logic aux_lvl, aux_fail_q, aux_short_q;
   logic signal_ground_q, limit_hit, fail_pulse;
   logic wr_done, stby_req, main_short, aux_short;
   logic [FLAG_W-1:0] set;

   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction

   persist_filter #(.CYCLES(FAIL_CYC)) u_main_fail (
      .pclk(pclk), .presetn(presetn), .raw(main_below_fail), .hold(1'b0),
      .level(main_lvl), .q(main_fail_q));
   persist_filter #(.CYCLES(SHORT_CYCLES)) u_main_short (
      .pclk(pclk), .presetn(presetn), .raw(main_below_fail), .hold(!s.main_armed),
      .level(), .q(main_short_q));
   persist_filter #(.CYCLES(FAIL_CYC)) u_aux_fail (
      .pclk(pclk), .presetn(presetn), .raw(aux_below_fail), .hold(1'b0),
      .level(aux_lvl), .q(aux_fail_q));
   persist_filter #(.CYCLES(SHORT_CYCLES)) u_aux_short (
      .pclk(pclk), .presetn(presetn), .raw(aux_below_fail), .hold(!s.aux_armed),
      .level(), .q(aux_short_q));
   persist_filter #(.CYCLES(SIGNAL_GROUND_CYC)) u_signal_ground (
      .pclk(pclk), .presetn(presetn), .raw(signal_ground_cmp), .hold(1'b0),
      .level(), .q(signal_ground_q));
   fail_window #(.WINDOW(WINDOW_CYCLES)) u_window (
      .pclk(pclk), .presetn(presetn), .fail(fail_pulse), .limit_hit(limit_hit));

   always_comb begin
      n = s;
      fail_pulse = 1'b0;
      n.warn1 = thermal_warning_level;
      n.warn2 = s.warn1;
      n.sd1   = thermal_shutdown_level;
      n.sd2   = s.sd1;
      n.lost1 = supply_pin_lost;
      n.lost2 = s.lost1;
      n.wake1 = wake_event;
      n.wake2 = s.wake1;

      // one wait state: data is registered, so ready follows one cycle late
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      if (psel && penable && !s.pready) begin
         n.pready  = 1'b1;
         n.pslverr = !reg_hit(paddr, CTRL_OFS) && !reg_hit(paddr, STATUS_OFS);
         n.prdata  = '0;
         if (reg_hit(paddr, CTRL_OFS)) begin
            n.prdata[CTRL_W-1:0] = s.ctrl;
         end else if (reg_hit(paddr, STATUS_OFS)) begin
            n.prdata[FLAG_W-1:0]                   = s.flags;
            n.prdata[ST_WARN_BIT]                  = s.warn2;
            n.prdata[ST_SD_BIT]                    = s.sd2;
            n.prdata[ST_STATE_LSB +: $bits(s.state)] = s.state;
         end
      end
      wr_done  = psel && penable && s.pready && pwrite;
      stby_req = wr_done && reg_hit(paddr, CTRL_OFS) && pwdata[CTRL_STBY_REQ];
      if (wr_done && reg_hit(paddr, CTRL_OFS)) begin
         n.ctrl = pwdata[CTRL_W-1:0];
      end
      if (wr_done && reg_hit(paddr, STATUS_OFS)) begin
         n.flags = s.flags & ~pwdata[FLAG_W-1:0];
      end

      main_short = s.main_armed && main_short_q;
      aux_short  = s.aux_armed && aux_short_q;
      if (!main_lvl) begin
         n.main_armed = 1'b0;
      end
      if (!aux_lvl) begin
         n.aux_armed = 1'b0;
      end

      set = '0;
      set[F_MAIN_FAIL]  = main_fail_q || main_short;
      set[F_AUX_FAIL]   = aux_fail_q || aux_short;
      set[F_AUX_SHORT]  = aux_short;
      set[F_MAIN_SHORT] = main_short;
      set[F_FORCED]     = main_short || (s.state == ST_TSD && limit_hit);
      set[F_SIGNAL_GROUND]       = signal_ground_q;

      case (s.state)
         ST_ACTIVE: begin
            // the warning level alone leaves the main regulator running
            if (s.sd2) begin
               n.main_en    = 1'b0;
               n.main_armed = 1'b0;
               n.tmr        = 32'(RESTART_CYCLES);
               n.state      = ST_TSD;
            end else if (main_short) begin
               n.main_en    = 1'b0;
               n.main_armed = 1'b0;
               n.aux_en     = n.aux_en && !s.ctrl[CTRL_AUX_OFF];
               n.state      = ST_STANDBY;
            end else if (stby_req) begin
               n.main_en = !s.ctrl[CTRL_MAIN_OFF];
               n.aux_en  = n.aux_en && !s.ctrl[CTRL_AUX_OFF];
               n.state   = ST_STANDBY;
            end
         end
         ST_TSD: begin
            if (limit_hit) begin
               n.aux_en = n.aux_en && !s.ctrl[CTRL_AUX_OFF];
               n.state  = ST_STANDBY;
            end else if (s.tmr != 32'h0) begin
               n.tmr = s.tmr - 32'h1;
            end else if (s.sd2) begin
               fail_pulse = 1'b1;
               n.tmr      = 32'(RESTART_CYCLES);
            end else begin
               n.main_en    = 1'b1;
               n.main_armed = 1'b1;
               n.state      = ST_ACTIVE;
            end
         end
         ST_STANDBY: begin
            if (s.wake2 && s.wake_en && !s.sd2) begin
               n.state      = ST_WAKE;
               n.tmr        = 32'(PULSE_CYC);
               n.rst_n      = 1'b0;
               n.main_en    = 1'b1;
               n.aux_en     = 1'b1;
               n.main_armed = !s.main_en;
               n.aux_armed  = !s.aux_en;
            end
         end
         ST_WAKE: begin
            if (main_short) begin
               // a short seen during the pulse cannot wait for the pulse to end
               n.main_en = 1'b0;
               n.aux_en  = n.aux_en && !s.ctrl[CTRL_AUX_OFF];
               n.state   = ST_STANDBY;
            end else if (s.tmr != 32'h0) begin
               n.tmr = s.tmr - 32'h1;
            end else begin
               n.rst_n = 1'b1;
               n.state = ST_ACTIVE;
            end
         end
         default: begin
            n.state = ST_ACTIVE;
         end
      endcase

      // after the state moves, so a wake cannot turn a shorted aux back on
      if (aux_short || (s.warn2 && !s.aux_armed && aux_lvl)) begin
         n.aux_en    = 1'b0;
         n.aux_armed = 1'b0;
      end
      // a regulator that is off reads low, which must not count as a short
      if (!n.main_en) begin
         n.main_armed = 1'b0;
      end
      if (!n.aux_en) begin
         n.aux_armed = 1'b0;
      end

      n.flags   = n.flags | set; // a set in the clearing cycle wins
      n.pwr_en  = (n.state == ST_ACTIVE || n.state == ST_WAKE) && !s.lost2;
      n.tx_en   = n.state == ST_ACTIVE;
      n.wake_en = n.state != ST_TSD;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= SUP_RST;
      end else begin
         s <= n;
      end
   end

   assign prdata                 = s.prdata;
   assign pready                 = s.pready;
   assign pslverr                = s.pslverr;
   assign main_regulator_en      = s.main_en;
   assign aux_regulator_en       = s.aux_en;
   assign aux_reg_mode_select    = s.ctrl[CTRL_AUX_MODE];
   assign reset_threshold_sel_hi = s.ctrl[CTRL_THR_HI];
   assign reset_threshold_sel_lo = s.ctrl[CTRL_THR_LO];
   assign power_out_en           = s.pwr_en;
   assign contact_supply_switch  = s.ctrl[CTRL_CONTACT];
   assign bus_tx_en              = s.tx_en;
   assign wake_sources_en        = s.wake_en;
   assign host_reset_output_n    = s.rst_n;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_wake;
      s.state == ST_STANDBY && s.wake2 && s.wake_en && !s.sd2;
   endsequence

   sequence s_short_in_wake;
      s.state == ST_WAKE && main_short;
   endsequence

   a_warn_keeps_main: assert property (
      s.state == ST_ACTIVE && s.main_en && s.warn2 && !s.sd2 && !main_short && !stby_req
      |=> s.main_en) else $error("main regulator dropped at warning level");
   a_tsd_main_off: assert property (
      s.state == ST_ACTIVE && s.sd2 |=> !s.main_en ##1 !s.wake_en)
      else $error("shutdown level left main regulator or wake on");
   a_restart_auto: assert property (
      s.state == ST_TSD && s.tmr == 32'h0 && !s.sd2 && !limit_hit
      |=> s.main_en && s.state == ST_ACTIVE) else $error("no automatic restart");
   a_forced_limit: assert property (
      s.state == ST_TSD && limit_hit |=> s.state == ST_STANDBY && s.flags[F_FORCED])
      else $error("restart limit did not force standby");
   a_mode_follows: assert property (
      wr_done && reg_hit(paddr, CTRL_OFS) |=> aux_reg_mode_select == $past(pwdata[CTRL_AUX_MODE]))
      else $error("aux mode bit not written");
   a_main_short: assert property (
      s.state == ST_ACTIVE && main_short && !s.sd2
      |=> s.state == ST_STANDBY && !s.main_en && s.flags[F_FORCED] && s.flags[F_MAIN_FAIL])
      else $error("main short handling wrong");
   a_aux_short: assert property (
      aux_short |=> !s.aux_en && s.flags[F_AUX_SHORT] && s.flags[F_AUX_FAIL])
      else $error("aux short handling wrong");
   a_supply_loss: assert property (
      s.lost2 |=> !s.pwr_en) else $error("power outputs on after supply loss");
   a_wake_pulse: assert property (
      s_wake |=> !s.rst_n ##1 !s.rst_n) else $error("no reset pulse on wake");

   a_wake_short: assert property (
      s_short_in_wake |=> s.state == ST_STANDBY && !s.main_en)
      else $error("main short during reset pulse not handled");
   a_fail_latch: assert property (
      main_fail_q |=> s.flags[F_MAIN_FAIL]) else $error("main fail flag not latched");
   a_signal_ground_flag: assert property (
      signal_ground_q |=> s.flags[F_SIGNAL_GROUND]) else $error("ground loss flag not set");
   // aux drops at warning only once short checking is over
   a_aux_warn_off: assert property (
      s.warn2 && !s.aux_armed && aux_lvl |=> !s.aux_en)
      else $error("aux left on at warning with a lasting short");
   a_stby_entry: assert property (
      s.state == ST_ACTIVE && stby_req && !s.sd2 && !main_short
      |=> s.state == ST_STANDBY && !s.tx_en && !s.pwr_en)
      else $error("standby request left transmitters or outputs on");
endmodule // regulator_fault_supervisor

// ### hw/fault_sup_pkg.sv
// shared constants, register map and timing of the regulator fault supervisor
package fault_sup_pkg;
   localparam int CLK_MHZ = 20;

   // register map, byte addresses on the APB
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;

   // control register fields
   localparam int CTRL_W        = 6;
   localparam int CTRL_AUX_MODE = 0;
   localparam int CTRL_THR_LO   = 1;
   localparam int CTRL_THR_HI   = 2;
   localparam int CTRL_MAIN_OFF = 3;
   localparam int CTRL_AUX_OFF  = 4;
   localparam int CTRL_CONTACT  = 5;
   localparam int CTRL_STBY_REQ = 8;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h18;

   // status register fields
   localparam int FLAG_W       = 6;
   localparam int F_MAIN_FAIL  = 0;
   localparam int F_AUX_FAIL   = 1;
   localparam int F_AUX_SHORT  = 2;
   localparam int F_FORCED     = 3;
   localparam int F_SIGNAL_GROUND       = 4;
   localparam int F_MAIN_SHORT = 5;
   localparam int ST_WARN_BIT  = 8;
   localparam int ST_SD_BIT    = 9;
   localparam int ST_STATE_LSB = 12;

   // times in their own units
   localparam longint SIGNAL_GROUND_FILTER_NS   = 7000;
   localparam longint FAIL_FILTER_NS   = 2000;
   localparam longint SHORT_FILTER_NS  = 2000000;
   localparam longint RESTART_DELAY_NS = 10000000;
   localparam longint RESET_PULSE_NS   = 20000;
   localparam longint WINDOW_MS        = 60000;
   localparam int     RESTART_LIMIT    = 7;

   // least time in whole cycles, never below one
   function automatic longint cyc_min(input longint ns);
      longint r;
      r = (ns * CLK_MHZ + 999) / 1000;
      return (r < 1) ? 1 : r;
   endfunction

   localparam int SIGNAL_GROUND_CYC    = int'(cyc_min(SIGNAL_GROUND_FILTER_NS));
   localparam int FAIL_CYC    = int'(cyc_min(FAIL_FILTER_NS));
   localparam int SHORT_CYC   = int'(cyc_min(SHORT_FILTER_NS));
   localparam int RESTART_CYC = int'(cyc_min(RESTART_DELAY_NS));
   localparam int PULSE_CYC   = int'(cyc_min(RESET_PULSE_NS));
   localparam int WINDOW_CYC  = int'(cyc_min(WINDOW_MS * 1000000));

   typedef enum logic [3:0] {
      ST_ACTIVE  = 4'b0001,
      ST_TSD     = 4'b0010,
      ST_STANDBY = 4'b0100,
      ST_WAKE    = 4'b1000
   } sup_state_t;
endpackage

// ### hw/persist_filter.sv
// two-flop synchroniser followed by a persistence filter
module persist_filter #(
   parameter int CYCLES = 1
) (
   input  wire logic pclk,    // clock
   input  wire logic presetn, // async reset, active low
   input  wire logic raw,     // level from outside the clock domain
   input  wire logic hold,    // high keeps the filter cleared
   output logic      level,   // synchronised level
   output logic      q        // level qualified after CYCLES cycles
);
   typedef struct packed {
      logic        s1;
      logic        s2;
      logic        q;
      logic [31:0] cnt;
   } filt_t;

   filt_t s;
   filt_t n;

   always_comb begin
      n = s;
      n.s1 = raw;
      n.s2 = s.s1;
      if (!s.s2 || hold) begin
         n.cnt = '0;
         n.q   = 1'b0;
      end else if (s.cnt >= 32'(CYCLES - 1)) begin
         n.q = 1'b1;
      end else begin
         n.cnt = s.cnt + 32'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign level = s.s2;
   assign q     = s.q;

   a_filter_drop: assert property (@(posedge pclk) disable iff (!presetn)
      (!s.s2 || hold) |=> !s.q) else $error("filter output outlived its input");
endmodule // persist_filter

// ### hw/fail_window.sv
// sliding window counter of restart failures
module fail_window #(
   parameter int WINDOW = fault_sup_pkg::WINDOW_CYC
) (
   input  wire logic pclk,      // clock
   input  wire logic presetn,   // async reset, active low
   input  wire logic fail,      // one-cycle failure event
   output logic      limit_hit  // failures inside window reached the limit
);
   import fault_sup_pkg::*;

   typedef struct packed {
      logic [RESTART_LIMIT-1:0][31:0] age;
      logic [RESTART_LIMIT-1:0]       used;
      logic                           hit;
   } win_t;

   win_t s;
   win_t n;

   // each failure ages out on its own, so old ones stop counting
   always_comb begin
      logic done;
      done = 1'b0;
      n = s;
      for (int i = 0; i < RESTART_LIMIT; i++) begin
         if (s.used[i]) begin
            if (s.age[i] == 32'h0) begin
               n.used[i] = 1'b0;
            end else begin
               n.age[i] = s.age[i] - 32'h1;
            end
         end
      end
      for (int i = 0; i < RESTART_LIMIT; i++) begin
         if (fail && !done && !s.used[i]) begin
            n.used[i] = 1'b1;
            n.age[i]  = 32'(WINDOW - 1);
            done      = 1'b1;
         end
      end
      n.hit = &n.used;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign limit_hit = s.hit;

   a_window_full: assert property (@(posedge pclk) disable iff (!presetn)
      s.hit |-> (&s.used)) else $error("limit flagged without a full window");
endmodule // fail_window

// ### tb/host_model.sv
// host controller model: apb master that reads flags and sets configuration
module host_model (
   input  wire logic        pclk,    // clock
   input  wire logic [31:0] prdata,  // read data
   input  wire logic        pready,  // ready
   input  wire logic        pslverr, // error
   output logic             psel,    // select
   output logic             penable, // enable
   output logic             pwrite,  // direction
   output logic      [7:0]  paddr,   // byte address
   output logic      [31:0] pwdata   // write data
);
   timeunit 1ns;
   timeprecision 100ps;
   import fault_sup_pkg::*;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'hFF;
      pwdata = 32'h0;
   end

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle bus shows junk, not the last request
      paddr <= ~a;
      pwdata <= ~d;
   endtask

   task automatic wr_ctrl(input logic [CTRL_W-1:0] v);
      logic [31:0]       r;
      logic              e;
      logic [CTRL_W-1:0] t;
      t = v;
      if (t[CTRL_AUX_MODE]) begin
         t[CTRL_THR_LO] = 1'b1;
         t[CTRL_THR_HI] = 1'b1;
      end
      xfer(1'b1, CTRL_OFS, {26'h0, t}, r, e);
   endtask
endmodule // host_model

// ### tb/testbench.sv
// self-checking bench of the regulator fault supervisor
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import fault_sup_pkg::*;
   localparam int RC = 50;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, seed;
   logic [31:0] pwdata, prdata, rd;
   logic        twarn, tshut, main_low, aux_low, pin_lost, signal_ground, wake_event, er;
   logic        main_en, aux_en, mode, thr_hi, thr_lo, pout, contact, bus_tx, wake_en, rst_n;
   logic [5:0]  cv;
   int          errors, total_checks;

   always #25 pclk = ~pclk;

   host_model host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   regulator_fault_supervisor #(.RESTART_CYCLES(RC), .SHORT_CYCLES(20), .WINDOW_CYCLES(2000))
   uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .thermal_warning_level(twarn), .thermal_shutdown_level(tshut),
      .main_below_fail(main_low), .aux_below_fail(aux_low), .supply_pin_lost(pin_lost),
      .signal_ground_cmp(signal_ground), .wake_event(wake_event), .main_regulator_en(main_en),
      .aux_regulator_en(aux_en), .aux_reg_mode_select(mode),
      .reset_threshold_sel_hi(thr_hi), .reset_threshold_sel_lo(thr_lo),
      .power_out_en(pout), .contact_supply_switch(contact), .bus_tx_en(bus_tx),
      .wake_sources_en(wake_en), .host_reset_output_n(rst_n));

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   function automatic logic [5:0] fl(input logic mf, af, as, fs, ms);
      fl = 6'h00;
      fl[F_MAIN_FAIL] = mf;
      fl[F_AUX_FAIL] = af;
      fl[F_AUX_SHORT] = as;
      fl[F_FORCED] = fs;
      fl[F_MAIN_SHORT] = ms;
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic rd_st;
      host.xfer(1'b0, STATUS_OFS, 32'h0, rd, er);
   endtask

   task automatic clr;
      host.xfer(1'b1, STATUS_OFS, 32'h3F, rd, er);
   endtask

   task automatic wake;
      wake_event <= 1'b1;
      cyc(4);
      wake_event <= 1'b0;
      cyc(3);
   endtask

   task automatic end_of_test;
      if (errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // generous span: the whole sequence needs under two thousand cycles
   initial begin
      #1000000;
      errors++;
      end_of_test();
   end

   initial begin
      {pclk, presetn, twarn, tshut, main_low, aux_low, pin_lost, signal_ground, wake_event} = '0;
      errors = 0;
      total_checks = 0;
      seed = 8'h1E;
      cyc(3);
      presetn <= 1'b1;
      cyc(5);
      chk(rst_n, 1'b0);
      host.xfer(1'b0, CTRL_OFS, 32'h0, rd, er);
      chk(rd, {26'h0, CTRL_RST});
      chk(mode, 1'b0);
      host.xfer(1'b0, 8'h10, 32'h0, rd, er);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      cyc(420);
      chk(rst_n, 1'b1);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         cv = seed[5:0];
         cv[CTRL_AUX_MODE] = i[0];
         host.wr_ctrl(cv);
         cyc(2);
         chk(mode, i[0]);
         chk({thr_hi, thr_lo}, i[0] ? 2'h3 : {cv[CTRL_THR_HI], cv[CTRL_THR_LO]});
         chk(contact, cv[CTRL_CONTACT]);
      end
      host.wr_ctrl(6'h38);
      twarn <= 1'b1;
      cyc(10);
      chk(main_en, 1'b1);
      twarn <= 1'b0;
      // glitch shorter than the fail filter leaves no flag
      seed = lfsr(seed);
      main_low <= 1'b1;
      cyc(1 + int'(seed[4:0]));
      main_low <= 1'b0;
      cyc(5);
      rd_st();
      chk(rd[5:0], 6'h00);
      {twarn, main_low, aux_low} <= 3'h7;
      cyc(50);
      chk({main_en, aux_en}, 2'h2);
      {twarn, main_low, aux_low} <= 3'h0;
      cyc(5);
      rd_st();
      chk(rd[5:0], fl(1, 1, 0, 0, 0));
      chk(main_en, 1'b1);
      clr();
      rd_st();
      chk(rd[5:0], 6'h00);
      signal_ground <= 1'b1;
      cyc(120);
      rd_st();
      chk(rd[F_SIGNAL_GROUND], 1'b0);
      cyc(30);
      rd_st();
      chk(rd[F_SIGNAL_GROUND], 1'b1);
      signal_ground <= 1'b0;
      cyc(3);
      clr();
      pin_lost <= 1'b1;
      cyc(5);
      chk(pout, 1'b0);
      pin_lost <= 1'b0;
      cyc(5);
      chk(pout, 1'b1);
      tshut <= 1'b1;
      cyc(5);
      chk({main_en, wake_en}, 2'b00);
      tshut <= 1'b0;
      cyc(RC + 10);
      chk(main_en, 1'b1);
      tshut <= 1'b1;
      cyc(6 * (RC + 1) + 25);
      rd_st();
      chk(rd[ST_STATE_LSB+:4], ST_TSD);
      cyc(40);
      rd_st();
      chk(rd[ST_STATE_LSB+:4], ST_STANDBY);
      chk(rd[F_FORCED], 1'b1);
      chk({bus_tx, pout, main_en, aux_en, contact}, 5'b00001);
      tshut <= 1'b0;
      cyc(5);
      wake();
      chk(rst_n, 1'b0);
      cyc(420);
      chk({rst_n, main_en, bus_tx}, 3'b111);
      host.xfer(1'b1, CTRL_OFS, 32'h0000_0138, rd, er);
      cyc(5);
      rd_st();
      chk(rd[ST_STATE_LSB+:4], ST_STANDBY);
      main_low <= 1'b1;
      cyc(3);
      clr();
      wake();
      cyc(40);
      rd_st();
      chk(rd[5:0] & fl(1, 0, 0, 1, 1), fl(1, 0, 0, 1, 1));
      chk(rd[ST_STATE_LSB+:4], ST_STANDBY);
      main_low <= 1'b0;
      aux_low <= 1'b1;
      cyc(5);
      clr();
      wake();
      cyc(40);
      chk(aux_en, 1'b0);
      rd_st();
      chk(rd[5:0] & fl(0, 1, 1, 0, 1), fl(0, 1, 1, 0, 0));
      chk(rd[ST_STATE_LSB+:4], ST_WAKE);
      end_of_test();
   end
endmodule // testbench
